// file: rtl/drf_consts.vh
// Purpose: Shared constants of the multiported data register file
// Assumes: Included by bare name from the design files
// Notes: Offsets are byte addresses on the register bus
`ifndef DRF_CONSTS_VH
`define DRF_CONSTS_VH

// Register bus map
`define DRF_OFF_MODE_CONTROL_ONE 4'h0
`define DRF_OFF_BANK_STATUS 4'h4
`define DRF_ADDR_W 4

// Mode control one reset value and bank select bit positions
`define DRF_MODE_CONTROL_ONE_RST 32'h0000_0000
`define DRF_UPPER_HALF_BANK_SELECT 7
`define DRF_LOWER_HALF_BANK_SELECT 10

// Bus responses
`define DRF_RESP_OKAY 2'h0
`define DRF_RESP_SLVERR 2'h2

// Architectural register count and the index bit that picks the half
`define DRF_ARCH_REGS 16
`define DRF_HALF_MSB 3

// Width of computation unit data and program bus
`define DRF_UNIT_W 32
`define DRF_PMD_W 48

// Multiplier operations
`define DRF_MUL_PLAIN 2'h0
`define DRF_MUL_ACC_ADD 2'h1
`define DRF_MUL_ACC_SUB 2'h2

// ALU operation codes seen by the pairing check
`define DRF_ALU_AVG 4'h2
`define DRF_ALU_DUAL 4'h8

// Combined-operation operand groups (top two index bits)
`define DRF_GRP_MUL_X 2'h0
`define DRF_GRP_MUL_Y 2'h1
`define DRF_GRP_ALU_X 2'h2
`define DRF_GRP_ALU_Y 2'h3

// Rounding bit position in the accumulator
`define DRF_ROUND_BIT 31
`define DRF_ACC_W 80
`define DRF_PROD_W 64

`endif

// file: rtl/drf_write_select.v
// Purpose: Picks the one write that lands on a single register name
// Assumes: Requests arrive ordered from highest to lowest precedence
// Notes: Purely combinational; one instance per architectural register
`timescale 1ns/100ps
`default_nettype none
module drf_write_select #(
   parameter DW = 40,
   parameter NREQ = 6,
   parameter [3:0] REG_IDX = 4'h0
) (
   input wire [NREQ-1:0] req_en,
   input wire [NREQ*4-1:0] req_addr,
   input wire [NREQ*DW-1:0] req_data,
   output reg wr_en,
   output reg [DW-1:0] wr_data
);
   integer k;

   // Scan lowest precedence first so the highest match overwrites it
   always @* begin
      wr_en = 1'b0;
      wr_data = {DW{1'b0}};
      for (k = NREQ - 1; k >= 0; k = k - 1) begin
         if (req_en[k] && (req_addr[k*4 +: 4] == REG_IDX)) begin
            wr_en = 1'b1;
            wr_data = req_data[k*DW +: DW];
         end
      end
   end
endmodule // drf_write_select
`default_nettype wire

// file: rtl/drf_register_file.v
// Purpose: Multiported data register file with banked halves and bus slave
// Assumes: Operand reads combinational, all writes land at the clock edge
// Notes: Mode control one reached over AXI4-Lite
//
// The register addresses and the AXI4-Lite slave port were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "drf_consts.vh"
module drf_register_file #(
   parameter DW = 40,
   parameter FLAG_W = 4
) (
   input wire clk,
   input wire rst_b,
   // AXI4-Lite slave
   input wire [`DRF_ADDR_W-1:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [`DRF_ADDR_W-1:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   // Operand selection
   input wire combined_op,
   input wire [3:0] op0_addr,
   input wire [3:0] op1_addr,
   input wire [3:0] op2_addr,
   input wire [3:0] op3_addr,
   output wire [`DRF_UNIT_W-1:0] op0_data,
   output wire [`DRF_UNIT_W-1:0] op1_data,
   output wire [`DRF_UNIT_W-1:0] op2_data,
   output wire [`DRF_UNIT_W-1:0] op3_data,
   // Data memory bus
   input wire dmd_wr_en,
   input wire [3:0] dmd_wr_addr,
   input wire [DW-1:0] data_memory_data_bus_in,
   input wire [3:0] dmd_rd_addr,
   output wire [DW-1:0] data_memory_data_bus_out,
   // Program memory bus
   input wire pmd_wr_en,
   input wire [3:0] pmd_wr_addr,
   input wire [`DRF_PMD_W-1:0] program_memory_data_bus_in,
   input wire [3:0] pmd_rd_addr,
   output wire [`DRF_PMD_W-1:0] program_memory_data_bus_out,
   // ALU sum and difference results
   input wire alu_sum_wr_en,
   input wire [3:0] alu_sum_addr,
   input wire [`DRF_UNIT_W-1:0] alu_sum_data,
   input wire alu_diff_wr_en,
   input wire [3:0] alu_diff_addr,
   input wire [`DRF_UNIT_W-1:0] alu_diff_data,
   input wire alu_dual,
   input wire [FLAG_W-1:0] alu_sum_flags,
   input wire [FLAG_W-1:0] alu_diff_flags,
   output reg [FLAG_W-1:0] alu_flags,
   // Multiplier results
   input wire mul_valid,
   input wire mul_fixed,
   input wire [1:0] mul_op,
   input wire [`DRF_PROD_W-1:0] mul_product,
   input wire [`DRF_UNIT_W-1:0] mul_float_result,
   input wire mul_wr_en,
   input wire [3:0] mul_addr,
   output reg [`DRF_ACC_W-1:0] foreground_product_accumulator,
   // Shifter result
   input wire shf_wr_en,
   input wire [3:0] shf_addr,
   input wire [`DRF_UNIT_W-1:0] shf_data,
   // Pairing check
   input wire [3:0] alu_kind,
   output wire pair_illegal
);
   localparam NREQ = 6;
   localparam LOWW = DW - `DRF_UNIT_W;
   localparam PMD_LOW = `DRF_PMD_W - DW;

   reg [DW-1:0] mem [0:2*`DRF_ARCH_REGS-1];
   reg [31:0] mode_control_one; // Software view of mode control
   reg upper_half_bank_select; // Active bank for registers 8-15
   reg lower_half_bank_select; // Active bank for registers 0-7
   reg aw_held; // Write address captured
   reg w_held; // Write data captured
   reg [`DRF_ADDR_W-1:0] aw_addr; // Captured write address
   reg [31:0] w_data; // Captured write data
   reg [3:0] w_strb; // Captured byte enables
   reg [31:0] next_mode; // Mode after byte merge
   reg [31:0] rd_val; // Read mux result
   reg rd_hit; // Read address mapped
   reg [`DRF_ACC_W-1:0] acc_sum; // Accumulate path result
   reg [`DRF_UNIT_W-1:0] mul_reg_data; // Multiplier word to the file
   wire [`DRF_ACC_W-1:0] prod_ext; // Sign-extended product
   wire [`DRF_UNIT_W-1:0] rounded; // Nearest-rounded fraction
   wire [NREQ-1:0] req_en;
   wire [NREQ*4-1:0] req_addr;
   wire [NREQ*DW-1:0] req_data;
   wire [`DRF_ARCH_REGS-1:0] we;
   wire [`DRF_ARCH_REGS*DW-1:0] wd;
   wire [3:0] eff0, eff1, eff2, eff3; // Effective operand names
   wire wr_fire;
   integer i; // Location index, storage process only
   integer j; // Byte lane index, kept apart from the storage loop

   // Map a name to its physical location through the half's select
   function [4:0] phys;
      input [3:0] a;
      input up_sel;
      input lo_sel;
      begin
         phys = {(a[`DRF_HALF_MSB] ? up_sel : lo_sel), a};
      end
   endfunction

   // Widen a 32-bit unit result into the top of a location
   function [DW-1:0] widen;
      input [`DRF_UNIT_W-1:0] v;
      begin
         widen = {v, {LOWW{1'b0}}};
      end
   endfunction

   // Combined multiplier/ALU forces each operand into its group
   assign eff0 = combined_op ? {`DRF_GRP_MUL_X, op0_addr[1:0]} : op0_addr;
   assign eff1 = combined_op ? {`DRF_GRP_MUL_Y, op1_addr[1:0]} : op1_addr;
   assign eff2 = combined_op ? {`DRF_GRP_ALU_X, op2_addr[1:0]} : op2_addr;
   assign eff3 = combined_op ? {`DRF_GRP_ALU_Y, op3_addr[1:0]} : op3_addr;

   // Reads see stored contents, so same-cycle writes do not leak in
   assign op0_data = mem[phys(eff0, upper_half_bank_select,
      lower_half_bank_select)][DW-1 -: `DRF_UNIT_W];
   assign op1_data = mem[phys(eff1, upper_half_bank_select,
      lower_half_bank_select)][DW-1 -: `DRF_UNIT_W];
   assign op2_data = mem[phys(eff2, upper_half_bank_select,
      lower_half_bank_select)][DW-1 -: `DRF_UNIT_W];
   assign op3_data = mem[phys(eff3, upper_half_bank_select,
      lower_half_bank_select)][DW-1 -: `DRF_UNIT_W];

   // Memory buses move whole locations, format never consulted
   assign data_memory_data_bus_out = mem[phys(dmd_rd_addr, upper_half_bank_select,
      lower_half_bank_select)];
   assign program_memory_data_bus_out = {mem[phys(pmd_rd_addr, upper_half_bank_select,
      lower_half_bank_select)], {PMD_LOW{1'b0}}};

   // Fixed multiplies pair with add, subtract, average, dual; float with all nine codes 0-8
   assign pair_illegal = combined_op & ((alu_kind > `DRF_ALU_DUAL) |
      (mul_fixed & (alu_kind > `DRF_ALU_AVG) & (alu_kind != `DRF_ALU_DUAL)));

   // Accumulate path uses the foreground accumulator as source
   assign prod_ext = {{(`DRF_ACC_W-`DRF_PROD_W){mul_product[`DRF_PROD_W-1]}}, mul_product};
   always @* begin
      case (mul_op)
         `DRF_MUL_ACC_ADD: acc_sum = foreground_product_accumulator + prod_ext;
         `DRF_MUL_ACC_SUB: acc_sum = foreground_product_accumulator - prod_ext;
         default: acc_sum = prod_ext;
      endcase
   end

   // Round to nearest on the upper word of the fraction
   assign rounded = acc_sum[`DRF_PROD_W-1 -: `DRF_UNIT_W] +
      {{(`DRF_UNIT_W-1){1'b0}}, acc_sum[`DRF_ROUND_BIT]};

   // Fixed results to a register are rounded, float passes untouched
   always @* begin
      if (mul_fixed) begin
         mul_reg_data = rounded;
      end else begin
         mul_reg_data = mul_float_result;
      end
   end

   // Requests in precedence order: data bus, program bus, ALU, multiplier, shifter
   assign req_en = {shf_wr_en, mul_valid & mul_wr_en, alu_diff_wr_en, alu_sum_wr_en,
      pmd_wr_en, dmd_wr_en};
   assign req_addr = {shf_addr, mul_addr, alu_diff_addr, alu_sum_addr, pmd_wr_addr,
      dmd_wr_addr};
   assign req_data = {widen(shf_data), widen(mul_reg_data), widen(alu_diff_data),
      widen(alu_sum_data), program_memory_data_bus_in[`DRF_PMD_W-1 -: DW],
      data_memory_data_bus_in};

   // One precedence selector per architectural name
   genvar g;
   generate
      for (g = 0; g < `DRF_ARCH_REGS; g = g + 1) begin : g_wsel
         localparam [31:0] GIDX = g; // Name served by this selector
         drf_write_select #(
            .DW(DW),
            .NREQ(NREQ),
            .REG_IDX(GIDX[3:0])
         ) u_sel (
            .req_en(req_en),
            .req_addr(req_addr),
            .req_data(req_data),
            .wr_en(we[g]),
            .wr_data(wd[g*DW +: DW])
         );
      end
   endgenerate

   // Storage: writes land at the edge, after this cycle's reads
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         for (i = 0; i < 2 * `DRF_ARCH_REGS; i = i + 1) begin
            mem[i] <= {DW{1'b0}};
         end
      end else begin
         for (i = 0; i < `DRF_ARCH_REGS; i = i + 1) begin
            if (we[i]) begin
               mem[phys(i[3:0], upper_half_bank_select,
                  lower_half_bank_select)] <= wd[i*DW +: DW];
            end
         end
      end
   end

   // Accumulator updates only when the result is not sent to a register
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         foreground_product_accumulator <= {`DRF_ACC_W{1'b0}};
      end else if (mul_valid && mul_fixed && !mul_wr_en) begin
         foreground_product_accumulator <= acc_sum;
      end
   end

   // ALU flags: dual add/subtract merges both sets
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         alu_flags <= {FLAG_W{1'b0}};
      end else if (alu_dual) begin
         alu_flags <= alu_sum_flags | alu_diff_flags;
      end else begin
         alu_flags <= alu_sum_flags;
      end
   end

   // Bank selects follow mode control one one cycle late
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         upper_half_bank_select <= 1'b0;
         lower_half_bank_select <= 1'b0;
      end else begin
         upper_half_bank_select <= mode_control_one[`DRF_UPPER_HALF_BANK_SELECT];
         lower_half_bank_select <= mode_control_one[`DRF_LOWER_HALF_BANK_SELECT];
      end
   end

   // Write channels accepted independently, one write in flight
   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready = !w_held && !s_axi_bvalid;
   assign wr_fire = aw_held && w_held;

   // Byte-lane merge into mode control one
   always @* begin
      next_mode = mode_control_one;
      for (j = 0; j < 4; j = j + 1) begin
         if (w_strb[j]) begin
            next_mode[j*8 +: 8] = w_data[j*8 +: 8];
         end
      end
   end

   // Capture address and data, then commit and respond
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= {`DRF_ADDR_W{1'b0}};
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `DRF_RESP_OKAY;
         mode_control_one <= `DRF_MODE_CONTROL_ONE_RST;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (wr_fire) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_bvalid <= 1'b1;
            // Only mode control one is writable; status and holes refuse
            if (aw_addr == `DRF_OFF_MODE_CONTROL_ONE) begin
               mode_control_one <= next_mode;
               s_axi_bresp <= `DRF_RESP_OKAY;
            end else begin
               s_axi_bresp <= `DRF_RESP_SLVERR;
            end
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Read decode; status shows the banks actually in force
   always @* begin
      rd_hit = 1'b1;
      rd_val = 32'h0000_0000;
      case (s_axi_araddr)
         `DRF_OFF_MODE_CONTROL_ONE: rd_val = mode_control_one;
         `DRF_OFF_BANK_STATUS: begin
            rd_val[`DRF_UPPER_HALF_BANK_SELECT] = upper_half_bank_select;
            rd_val[`DRF_LOWER_HALF_BANK_SELECT] = lower_half_bank_select;
         end
         default: rd_hit = 1'b0;
      endcase
   end

   // Read answers one cycle after the address is taken
   assign s_axi_arready = !s_axi_rvalid;
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= `DRF_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_val;
         s_axi_rresp <= rd_hit ? `DRF_RESP_OKAY : `DRF_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
endmodule // drf_register_file
`default_nettype wire

// file: dv/drf_rf_chk.sv
// Purpose: Port checks of the data register file
// Assumes: Bound onto each drf_register_file
// Notes: Reads are combinational, so operand and bus read checks are in-cycle
`timescale 1ns/100ps
`default_nettype none
module drf_rf_chk #(
   parameter DW = 40,
   parameter FLAG_W = 4
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_bvalid,
   input wire logic combined_op,
   input wire logic [3:0] op0_addr,
   input wire logic [31:0] op0_data,
   input wire logic dmd_wr_en,
   input wire logic [3:0] dmd_wr_addr,
   input wire logic [DW-1:0] data_memory_data_bus_in,
   input wire logic [3:0] dmd_rd_addr,
   input wire logic [DW-1:0] data_memory_data_bus_out,
   input wire logic pmd_wr_en,
   input wire logic [3:0] pmd_wr_addr,
   input wire logic [47:0] program_memory_data_bus_in,
   input wire logic [3:0] pmd_rd_addr,
   input wire logic [47:0] program_memory_data_bus_out,
   input wire logic alu_dual,
   input wire logic [FLAG_W-1:0] alu_sum_flags,
   input wire logic [FLAG_W-1:0] alu_diff_flags,
   input wire logic [FLAG_W-1:0] alu_flags
);
   // One clock domain, so shared clocking and reset
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   // Program bus low byte never carries data
   a_pm_low_zero: assert property (program_memory_data_bus_out[7:0] == 8'h00)
      else $error("program bus low byte not zero");
   // Unit read is the top 32 bits of the same location
   a_op_upper: assert property (!combined_op && op0_addr == dmd_rd_addr |->
      op0_data == data_memory_data_bus_out[DW-1:DW-32]) else $error("operand not upper bits");
   // Data bus write always wins and keeps every bit
   a_dm_lands: assert property (dmd_wr_en && dmd_rd_addr == dmd_wr_addr && !s_axi_bvalid
      |=> !$stable(dmd_rd_addr) || data_memory_data_bus_out == $past(data_memory_data_bus_in))
      else $error("data bus write lost");
   // Program bus write stores its top bits
   a_pm_top: assert property (pmd_wr_en && !dmd_wr_en && pmd_rd_addr == pmd_wr_addr
      && !s_axi_bvalid |=> !$stable(pmd_rd_addr) || program_memory_data_bus_out[47:8]
      == $past(program_memory_data_bus_in[47:8])) else $error("program bus write lost");
   // Dual operation merges both flag sets
   a_flag_dual: assert property (rst_b && alu_dual |=>
      alu_flags == ($past(alu_sum_flags) | $past(alu_diff_flags))) else $error("dual flags");
   // Single operation keeps its own flags
   a_flag_single: assert property (rst_b && !alu_dual |=>
      alu_flags == $past(alu_sum_flags)) else $error("single flags");
   // Combined operation forces multiplier X group
   a_mul_group: assert property (combined_op && dmd_rd_addr == {2'h0, op0_addr[1:0]} |->
      op0_data == data_memory_data_bus_out[DW-1:DW-32]) else $error("operand group");
   // Register read answers on the next cycle
   a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
endmodule // drf_rf_chk
bind drf_register_file drf_rf_chk #(.DW(DW), .FLAG_W(FLAG_W)) drf_rf_chk_inst (.*);
`default_nettype wire

// file: dv/drf_alu_model.sv
// Purpose: ALU standing beside the register file
// Assumes: Operands come from the ALU X and Y ports
// Notes: Answers in the same cycle, like the real unit
`timescale 1ns/100ps
`default_nettype none
module drf_alu_model (
   input wire logic [31:0] op2_data,
   input wire logic [31:0] op3_data,
   output logic [31:0] alu_sum_data,
   output logic [31:0] alu_diff_data,
   output logic [3:0] alu_sum_flags,
   output logic [3:0] alu_diff_flags
);
   // Sum and difference of the same operand pair
   assign alu_sum_data = op2_data + op3_data;
   assign alu_diff_data = op2_data - op3_data;
   // Flags: bit 1 negative, bit 0 zero
   assign alu_sum_flags = {2'h0, alu_sum_data[31], alu_sum_data == 32'h0000_0000};
   assign alu_diff_flags = {2'h0, alu_diff_data[31], alu_diff_data == 32'h0000_0000};
endmodule // drf_alu_model
`default_nettype wire

// file: dv/testbench.sv
// Purpose: Self-checking bench of the data register file
// Assumes: Bus tasks start just after a rising edge
// Notes: Outputs sampled at the falling edge, where settled
`timescale 1ns/100ps
`default_nettype none
`include "drf_consts.vh"
module testbench;
   logic clk, rst_b, combined_op, dmd_wr_en, pmd_wr_en, alu_sum_wr_en, alu_diff_wr_en;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, alu_dual, pair_illegal;
   logic mul_valid, mul_fixed, mul_wr_en, shf_wr_en;
   logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb, op0_addr, op1_addr, op2_addr, op3_addr;
   logic [3:0] dmd_wr_addr, dmd_rd_addr, pmd_wr_addr, pmd_rd_addr, alu_sum_addr, alu_diff_addr;
   logic [3:0] mul_addr, shf_addr, alu_kind, alu_sum_flags, alu_diff_flags, alu_flags;
   logic [31:0] s_axi_wdata, s_axi_rdata, op0_data, op1_data, op2_data, op3_data, d;
   logic [31:0] alu_sum_data, alu_diff_data, mul_float_result, shf_data;
   logic [1:0] s_axi_bresp, s_axi_rresp, mul_op, r;
   logic [39:0] data_memory_data_bus_in, data_memory_data_bus_out, pe [6];
   logic [47:0] program_memory_data_bus_in, program_memory_data_bus_out;
   logic [63:0] mul_product;
   logic [79:0] foreground_product_accumulator;
   int miscompares, total_checks, i;
   // Device and its ALU partner, joined by name
   drf_register_file drf_register_file_inst (.*);
   drf_alu_model drf_alu_model_inst (.*);
   // 20 MHz clock
   initial begin
      clk = 1'h0;
      forever #25 clk = ~clk;
   end
   // Verdict, the only end of the run
   task automatic print_verdict;
      if (miscompares == 0 && total_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // Compare, report a difference at once
   task automatic chk(input logic [79:0] got, input logic [79:0] exp);
      total_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask
   // One register bus write or read, bounded wait
   task automatic axi(input logic wr, input logic [3:0] a, input logic [31:0] wd);
      logic aw, w, ar, done;
      done = 1'h0;
      if (wr) begin
         s_axi_awaddr <= a;
         s_axi_wdata <= wd;
         s_axi_awvalid <= 1'h1;
         s_axi_wvalid <= 1'h1;
         s_axi_bready <= 1'h1;
      end else begin
         s_axi_araddr <= a;
         s_axi_arvalid <= 1'h1;
         s_axi_rready <= 1'h1;
      end
      for (int n = 0; n < 40 && !done; n++) begin
         @(negedge clk);
         aw = s_axi_awvalid && s_axi_awready;
         w = s_axi_wvalid && s_axi_wready;
         ar = s_axi_arvalid && s_axi_arready;
         done = wr ? s_axi_bvalid : s_axi_rvalid;
         r = wr ? s_axi_bresp : s_axi_rresp;
         d = s_axi_rdata;
         @(posedge clk);
         if (aw) s_axi_awvalid <= 1'h0;
         if (w) s_axi_wvalid <= 1'h0;
         if (ar) s_axi_arvalid <= 1'h0;
         if (done) {s_axi_bready, s_axi_rready} <= 2'h0;
      end
      @(posedge clk);
      if (!done) begin
         miscompares++;
         print_verdict();
      end
   endtask
   // Data bus write, lands at the next edge
   task automatic dw(input logic [3:0] a, input logic [39:0] v);
      dmd_wr_en <= 1'h1;
      dmd_wr_addr <= a;
      data_memory_data_bus_in <= v;
      @(posedge clk);
      dmd_wr_en <= 1'h0;
      @(posedge clk);
   endtask
   // Read one name on both buses and an operand port
   task automatic rd(input logic [3:0] a, input logic [39:0] v);
      dmd_rd_addr <= a;
      pmd_rd_addr <= a;
      op0_addr <= a;
      @(negedge clk);
      chk(data_memory_data_bus_out, v);
      chk(program_memory_data_bus_out, {v, 8'h00});
      chk(op0_data, v[39:8]);
      @(posedge clk);
   endtask
   // Main sequence
   initial begin
      {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready, s_axi_araddr,
       s_axi_arvalid, s_axi_rready, combined_op, op0_addr, op1_addr, dmd_wr_en, dmd_wr_addr,
       data_memory_data_bus_in, dmd_rd_addr, pmd_wr_en, pmd_wr_addr, pmd_rd_addr, alu_dual,
       program_memory_data_bus_in, alu_sum_wr_en, alu_sum_addr, alu_diff_wr_en, alu_diff_addr,
       mul_valid, mul_fixed, mul_op, mul_product, mul_float_result, mul_wr_en, mul_addr,
       shf_wr_en, shf_addr, shf_data, alu_kind} <= '0;
      op2_addr <= 4'h8;
      op3_addr <= 4'hC;
      s_axi_wstrb <= 4'hF;
      rst_b <= 1'h0;
      repeat (10) @(posedge clk);
      rst_b <= 1'h1;
      @(posedge clk);
      // Reset value, refused places
      axi(1'h0, `DRF_OFF_MODE_CONTROL_ONE, 32'h0000_0000);
      chk(d, `DRF_MODE_CONTROL_ONE_RST);
      axi(1'h0, 4'h8, 32'h0000_0000);
      chk({r, d}, {`DRF_RESP_SLVERR, 32'h0000_0000});
      axi(1'h1, `DRF_OFF_BANK_STATUS, 32'h0000_0480);
      chk(r, `DRF_RESP_SLVERR);
      // Every name keeps full width in the reset banks
      for (i = 0; i < 16; i++) begin
         dw(4'(i), {4'(i), 36'hA_5C3E_1F0D});
         rd(4'(i), {4'(i), 36'hA_5C3E_1F0D});
      end
      // ALU operands for the partner: sum positive, difference negative
      dw(4'h8, {32'h0000_0010, 8'hFF});
      dw(4'hC, {32'h0000_0030, 8'h00});
      // Six writers on one name, highest dropped in turn
      pe = '{40'h11_2233_4455, 40'h66_7788_99AA, {32'h0000_0040, 8'h00},
             {32'hFFFF_FFE0, 8'h00}, {32'h5555_0000, 8'h00}, {32'h7777_0000, 8'h00}};
      mul_float_result <= 32'h5555_0000;
      shf_data <= 32'h7777_0000;
      program_memory_data_bus_in <= 48'h6677_8899_AABB;
      {dmd_wr_addr, pmd_wr_addr, alu_sum_addr, alu_diff_addr, mul_addr, shf_addr} <= {6{4'h5}};
      mul_valid <= 1'h1;
      for (i = 0; i < 6; i++) begin
         data_memory_data_bus_in <= pe[0];
         {dmd_wr_en, pmd_wr_en, alu_sum_wr_en, alu_diff_wr_en, mul_wr_en, shf_wr_en} <= 6'h3F >> i;
         @(posedge clk);
         {dmd_wr_en, pmd_wr_en, alu_sum_wr_en, alu_diff_wr_en, mul_wr_en, shf_wr_en} <= 6'h00;
         rd(4'h5, pe[i]);
      end
      mul_valid <= 1'h0;
      // Read and write of one name in one cycle
      op0_addr <= 4'h5;
      shf_data <= 32'h1234_5678;
      shf_wr_en <= 1'h1;
      @(negedge clk);
      chk(op0_data, 32'h7777_0000);
      @(posedge clk);
      shf_wr_en <= 1'h0;
      @(negedge clk);
      chk(op0_data, 32'h1234_5678);
      @(posedge clk);
      // Both memory buses in one cycle
      pmd_wr_addr <= 4'h3;
      pmd_wr_en <= 1'h1;
      dw(4'h1, 40'hC0_FFEE_0001);
      pmd_wr_en <= 1'h0;
      rd(4'h1, 40'hC0_FFEE_0001);
      rd(4'h3, 40'h66_7788_99AA);
      // Dual flags merge, then single flags
      alu_dual <= 1'h1;
      @(posedge clk);
      alu_dual <= 1'h0;
      @(negedge clk);
      chk(alu_flags, 4'h2);
      @(negedge clk);
      chk(alu_flags, 4'h0);
      @(posedge clk);
      // Accumulate, then rounded write, then subtract
      {mul_valid, mul_fixed, mul_op} <= {2'h3, `DRF_MUL_ACC_ADD};
      mul_product <= 64'h0000_0001_8000_0000;
      @(posedge clk);
      mul_product <= 64'h0000_0000_0000_0000;
      mul_wr_en <= 1'h1;
      mul_addr <= 4'h6;
      @(negedge clk);
      chk(foreground_product_accumulator, 80'h1_8000_0000);
      @(posedge clk);
      {mul_valid, mul_wr_en} <= 2'h0;
      rd(4'h6, {32'h0000_0002, 8'h00});
      chk(foreground_product_accumulator, 80'h1_8000_0000);
      {mul_valid, mul_op} <= {1'h1, `DRF_MUL_ACC_SUB};
      mul_product <= 64'h0000_0001_8000_0000;
      @(posedge clk);
      mul_valid <= 1'h0;
      @(negedge clk);
      chk(foreground_product_accumulator, 80'h0);
      @(posedge clk);
      // Combined operand group and pairing table
      combined_op <= 1'h1;
      op0_addr <= 4'hF;
      op1_addr <= 4'hE;
      op3_addr <= 4'h1;
      dmd_rd_addr <= 4'h3;
      @(negedge clk);
      chk(op0_data, 32'h6677_8899);
      chk(op1_data, 32'h0000_0002);
      chk(op3_data, 32'hDA5C_3E1F);
      @(posedge clk);
      for (i = 0; i < 32; i++) begin
         mul_valid <= 1'h1;
         mul_fixed <= i < 16;
         alu_kind <= 4'(i);
         @(negedge clk);
         chk(pair_illegal, i % 16 > 8 || (i < 16 && !(i inside {0, 1, 2, 8})));
         @(posedge clk);
      end
      {combined_op, mul_valid} <= 2'h0;
      // Bank halves switch on their own select bits
      dw(4'h2, 40'h22_2222_2222);
      dw(4'hA, 40'hAA_AAAA_AAAA);
      axi(1'h1, `DRF_OFF_MODE_CONTROL_ONE, 32'h0000_0080);
      chk(r, `DRF_RESP_OKAY);
      rd(4'h2, 40'h22_2222_2222);
      rd(4'hA, 40'h00_0000_0000);
      dw(4'hA, 40'h55_5555_5555);
      axi(1'h0, `DRF_OFF_BANK_STATUS, 32'h0000_0000);
      chk(d, 32'h0000_0080);
      axi(1'h1, `DRF_OFF_MODE_CONTROL_ONE, 32'h0000_0400);
      axi(1'h0, `DRF_OFF_MODE_CONTROL_ONE, 32'h0000_0000);
      chk(d, 32'h0000_0400);
      rd(4'hA, 40'hAA_AAAA_AAAA);
      rd(4'h2, 40'h00_0000_0000);
      print_verdict();
   end
endmodule // testbench
`default_nettype wire
